// ==== rtl/oscc_control.sv ====
// Oscillator control registers, key locking and clock routing
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Two writes E7 then 18 to a register unlock it for one write.
// - After one accepted configuration write the register locks again.
// - Secondary control bit 7 enables the 32 kHz slow oscillator.
// - Bit 6 reads one only while the slow oscillator is stable and running.
// - Bits 2 to 0 pick precision oscillator frequency, halving per code; code 6 is a quarter of code 5.
// - During reset the crystal enable is the inverse of the crystal disable option.
// - No divider: system clock is the source, timer clock the slow input.
// - The slow oscillator clocks only the timers.
// - Main oscillator mode comes from option bits: medium, maximum, RC.
// - Slow oscillator mode is crystal or external clock, never RC.
// - Primary select code 010 makes the crystal the system clock.
// - Primary bit 6 enables the crystal and owns the crystal pins.
module oscc_control
  import oscc_pkg::*;
(
  input  wire logic                     clock_i,
  input  wire logic                     resetn_i,
  input  wire logic                     ce_i,
  input  wire logic [oscc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [oscc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic [oscc_pkg::DATA_W-1:0]   rd_data_o,
  output logic                          irq_o,
  input  wire logic                     crystal_disable_option_i,
  input  wire logic [1:0]               main_mode_option_i,
  input  wire logic                     slow_mode_option_i,
  input  wire logic                     slow_osc_stable_i,
  input  wire logic                     slow_osc_input_i,
  input  wire logic                     ipo_clock_i,
  input  wire logic                     crystal_clock_i,
  input  wire logic                     wdt_clock_i,
  input  wire logic                     ext_clock_i,
  output logic                          slow_osc_enable_o,
  output logic                          slow_osc_ready_o,
  output logic [2:0]                    rc_frequency_select_o,
  output logic [23:0]                   rc_frequency_hz_o,
  output logic                          ipo_enable_o,
  output logic                          wdt_osc_enable_o,
  output logic                          crystal_enable_o,
  output logic                          crystal_pins_owned_o,
  output logic [2:0]                    system_clock_select_o,
  output logic                          system_clock_o,
  output logic                          timer_clock_o,
  output oscc_pkg::oscc_main_mode_t     main_osc_mode_o,
  output logic                          slow_osc_ext_clock_o
);
  import oscc_pkg::*;

  typedef struct packed {
    logic                  booted;
    logic [7:0]            primary;
    logic [7:0]            secondary;
    logic [23:0]           ipo_hz;
    logic [IRQ_W-1:0]      status;
    logic [IRQ_W-1:0]      enable;
    logic                  rdy_prev;
    logic [7:0]            rdata;
    oscc_main_mode_t       main_mode;
    logic                  slow_ext;
  } oscc_ctl_state_t;

  oscc_ctl_state_t  state_r;
  oscc_ctl_state_t  state_nxt;

  logic             pri_wr;
  logic             sec_wr;
  logic             pri_accept;
  logic             sec_accept;
  logic             pri_ignored;
  logic             sec_ignored;
  logic             pri_broken;
  logic             sec_broken;
  logic             pri_unlocked;
  logic             sec_unlocked;
  logic             stable_sync;
  logic             ready;
  logic             clr_wr;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clear_mask;
  logic [IRQ_W-1:0] status_next;
  logic [7:0]       sec_view;

  // ************************************************************
  // Register decode and key locks
  // ************************************************************
  assign pri_wr = wr_i && addr_i == OFS_PRIMARY;
  assign sec_wr = wr_i && addr_i == OFS_SECONDARY;
  assign clr_wr = wr_i && ce_i && addr_i == OFS_IRQ_CLEAR;

  oscc_key_lock u_pri_lock (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .write_i    (pri_wr),
    .data_i     (wr_data_i),
    .accept_o   (pri_accept),
    .ignored_o  (pri_ignored),
    .broken_o   (pri_broken),
    .unlocked_o (pri_unlocked)
  );

  oscc_key_lock u_sec_lock (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .write_i    (sec_wr),
    .data_i     (wr_data_i),
    .accept_o   (sec_accept),
    .ignored_o  (sec_ignored),
    .broken_o   (sec_broken),
    .unlocked_o (sec_unlocked)
  );

  // ************************************************************
  // Ready flag
  // ************************************************************
  // Analog stable flag is asynchronous to the system clock
  oscc_sync2 u_stable_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .async_i  (slow_osc_stable_i),
    .sync_o   (stable_sync)
  );

  // Not running while disabled, whatever the analog flag says
  assign ready = stable_sync & state_r.secondary[SEC_EN_BIT];

  // ************************************************************
  // Interrupt status, set wins over clear
  // ************************************************************
  always_comb begin
    events                = '0;
    events[EV_RDY_RISE]   = ready & ~state_r.rdy_prev;
    events[EV_RDY_FALL]   = ~ready & state_r.rdy_prev;
    events[EV_LOCKED]     = pri_ignored | sec_ignored;
    events[EV_KEY_BROKEN] = pri_broken | sec_broken;
  end

  assign clear_mask = clr_wr ? wr_data_i[IRQ_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++) begin : g_status
      assign status_next[gi] = events[gi] | (state_r.status[gi] & ~clear_mask[gi]);
    end
  endgenerate

  // ************************************************************
  // Read view of the secondary register
  // ************************************************************
  always_comb begin
    sec_view              = state_r.secondary;
    sec_view[SEC_RDY_BIT] = ready;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    if (ce_i) begin
      state_nxt.rdy_prev = ready;
      state_nxt.status   = status_next;
      // Option bits are caught once, on the first clock-enabled edge after release
      if (!state_r.booted) begin
        state_nxt.booted                = 1'b1;
        state_nxt.primary[PRI_XTAL_BIT] = ~crystal_disable_option_i;
        state_nxt.slow_ext              = slow_mode_option_i;
        case (main_mode_option_i)
          2'b00:   state_nxt.main_mode = MODE_MEDIUM;
          2'b01:   state_nxt.main_mode = MODE_MAXIMUM;
          default: state_nxt.main_mode = MODE_RC_EXT;
        endcase
      end
      if (pri_accept) begin
        state_nxt.primary = wr_data_i;
      end
      if (sec_accept) begin
        // Ready bit is not stored; reserved bits keep what was written
        state_nxt.secondary              = wr_data_i;
        state_nxt.secondary[SEC_RDY_BIT] = 1'b0;
        state_nxt.ipo_hz                 = oscc_ipo_hz(wr_data_i[SEL_HI:SEL_LO]);
      end
      if (wr_i && addr_i == OFS_IRQ_ENABLE) begin
        state_nxt.enable = wr_data_i[IRQ_W-1:0];
      end
      if (rd_i) begin
        case (addr_i)
          OFS_PRIMARY:    state_nxt.rdata = state_r.primary;
          OFS_SECONDARY:  state_nxt.rdata = sec_view;
          OFS_IRQ_STATUS: state_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, state_r.status};
          OFS_IRQ_ENABLE: state_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, state_r.enable};
          default:        state_nxt.rdata = DATA_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r.booted    <= 1'b0;
      state_r.primary   <= PRI_RESET;
      state_r.secondary <= SEC_RESET;
      state_r.ipo_hz    <= IPO_BASE_HZ;
      state_r.status    <= '0;
      state_r.enable    <= '0;
      state_r.rdy_prev  <= 1'b0;
      state_r.rdata     <= DATA_ZERO;
      state_r.main_mode <= MODE_MEDIUM;
      state_r.slow_ext  <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Outputs and clock routing
  // ************************************************************
  assign rd_data_o             = state_r.rdata;
  assign irq_o                 = |(state_r.status & state_r.enable);
  assign slow_osc_enable_o     = state_r.secondary[SEC_EN_BIT];
  assign slow_osc_ready_o      = ready;
  assign rc_frequency_select_o = state_r.secondary[SEL_HI:SEL_LO];
  assign rc_frequency_hz_o     = state_r.ipo_hz;
  assign ipo_enable_o          = state_r.primary[PRI_IPO_BIT];
  assign wdt_osc_enable_o      = state_r.primary[PRI_WDT_BIT];
  assign system_clock_select_o = state_r.primary[SEL_HI:SEL_LO];
  assign main_osc_mode_o       = state_r.main_mode;
  assign slow_osc_ext_clock_o  = state_r.slow_ext;

  // Option straps drive the crystal while reset holds the registers
  assign crystal_enable_o     = state_r.booted ? state_r.primary[PRI_XTAL_BIT]
                                               : ~crystal_disable_option_i;
  assign crystal_pins_owned_o = crystal_enable_o;

  // Plain mux, no divider; switch only between settled sources
  always_comb begin
    case (system_clock_select_o)
      SCK_XTAL: system_clock_o = crystal_clock_i;
      SCK_WDT:  system_clock_o = wdt_clock_i;
      SCK_EXT:  system_clock_o = ext_clock_i;
      default:  system_clock_o = ipo_clock_i;
    endcase
  end

  // Slow source feeds the timer clock alone, undivided
  assign timer_clock_o = slow_osc_input_i & slow_osc_enable_o;

  // ************************************************************
  // Checks
  // ************************************************************
  a_locked_write_ignored: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && sec_wr && !sec_unlocked) |=> $stable(state_r.secondary))
    else $error("locked secondary register changed");

  a_enable_follows_write: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    sec_accept |=> (slow_osc_enable_o == $past(wr_data_i[SEC_EN_BIT])))
    else $error("slow oscillator enable did not follow write");

  a_ready_needs_enable: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    !slow_osc_enable_o |-> !slow_osc_ready_o)
    else $error("ready shown while slow oscillator disabled");

  a_ready_tracks_stable: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && slow_osc_enable_o && slow_osc_stable_i)[*3] |-> slow_osc_ready_o)
    else $error("ready flag missed a stable oscillator");

  a_freq_code_decode: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    sec_accept |=> (rc_frequency_hz_o == oscc_ipo_hz($past(wr_data_i[SEL_HI:SEL_LO]))))
    else $error("precision oscillator frequency wrong");

  a_crystal_reset_option: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && !state_r.booted) |=> (crystal_enable_o == $past(!crystal_disable_option_i)))
    else $error("crystal enable lost the option at boot");

  a_irq_set_wins: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && events[EV_LOCKED]) |=> state_r.status[EV_LOCKED])
    else $error("locked-write event lost");

  a_primary_locked: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && pri_wr && !pri_unlocked && state_r.booted) |=> $stable(state_r.primary))
    else $error("locked primary register changed");

  a_primary_relock: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    pri_accept |=> !pri_unlocked)
    else $error("primary register stayed unlocked after a write");

  a_select_follows_write: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    pri_accept |=> (system_clock_select_o == $past(wr_data_i[SEL_HI:SEL_LO])))
    else $error("system clock select did not follow write");

  a_pins_follow_write: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    pri_accept |=> (crystal_pins_owned_o == $past(wr_data_i[PRI_XTAL_BIT])))
    else $error("crystal pin ownership did not follow write");

  a_ready_not_stored: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    sec_accept |=> !state_r.secondary[SEC_RDY_BIT])
    else $error("written ready bit was stored");

  a_ready_bit_read: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && rd_i && addr_i == OFS_SECONDARY) |=> (rd_data_o[SEC_RDY_BIT] == $past(slow_osc_ready_o)))
    else $error("ready bit read back wrong");

  a_slow_mode_capture: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && !state_r.booted) |=> (slow_osc_ext_clock_o == $past(slow_mode_option_i)))
    else $error("slow oscillator mode not taken at boot");

  a_freq_held: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    !sec_accept |=> $stable(rc_frequency_hz_o))
    else $error("precision oscillator frequency changed without a write");

  a_broken_event_kept: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (ce_i && events[EV_KEY_BROKEN]) |=> state_r.status[EV_KEY_BROKEN])
    else $error("broken-key event lost");

endmodule

// ==== rtl/oscc_key_lock.sv ====
// Two-byte unlock key detector guarding one register
`timescale 1ns/1ps
module oscc_key_lock
  import oscc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic       write_i,
  input  wire logic [7:0] data_i,
  output logic            accept_o,
  output logic            ignored_o,
  output logic            broken_o,
  output logic            unlocked_o
);
  typedef struct packed {
    oscc_key_state_t st;
  } oscc_lock_state_t;

  oscc_lock_state_t state_r;
  oscc_lock_state_t state_nxt;
  logic             wr;

  assign wr = write_i & ce_i;

  // ************************************************************
  // Key sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    accept_o  = 1'b0;
    ignored_o = 1'b0;
    broken_o  = 1'b0;
    case (state_r.st)
      KEY_LOCKED: begin
        if (wr && data_i == KEY_FIRST) begin
          state_nxt.st = KEY_HALF;
        end else if (wr) begin
          ignored_o = 1'b1;
        end
      end
      KEY_HALF: begin
        if (wr && data_i == KEY_SECOND) begin
          state_nxt.st = KEY_OPEN;
        end else if (wr) begin
          broken_o     = 1'b1;
          // A fresh first byte restarts the key at once
          state_nxt.st = (data_i == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
        end
      end
      KEY_OPEN: begin
        if (wr) begin
          accept_o     = 1'b1;
          state_nxt.st = KEY_LOCKED;
        end
      end
      default: begin
        state_nxt.st = KEY_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r.st <= KEY_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign unlocked_o = (state_r.st == KEY_OPEN);

  a_key_second_opens: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    (wr && state_r.st == KEY_HALF && data_i == KEY_SECOND) |=> unlocked_o)
    else $error("second key byte did not unlock");

  a_relock_after_write: assert property (
    @(posedge clock_i) disable iff (!resetn_i)
    accept_o |=> !unlocked_o)
    else $error("register stayed unlocked after a write");

endmodule

// ==== rtl/oscc_pkg.sv ====
// Shared constants and types of the oscillator control block
package oscc_pkg;

  // ************************************************************
  // Register bus and map
  // ************************************************************
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 8;
  localparam logic [11:0] OFS_PRIMARY    = 12'hF86;
  localparam logic [11:0] OFS_SECONDARY  = 12'hF87;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'hF88;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'hF89;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'hF8A;

  // ************************************************************
  // Unlock key and reset values
  // ************************************************************
  localparam logic [7:0] KEY_FIRST   = 8'hE7;
  localparam logic [7:0] KEY_SECOND  = 8'h18;
  localparam logic [7:0] PRI_RESET   = 8'hA0;
  localparam logic [7:0] SEC_RESET   = 8'h20;
  localparam logic [7:0] DATA_ZERO   = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SEC_EN_BIT   = 7;
  localparam int SEC_RDY_BIT  = 6;
  localparam int SEC_RSV_HI   = 5;
  localparam int SEC_RSV_LO   = 3;
  localparam int SEL_HI       = 2;
  localparam int SEL_LO       = 0;
  localparam int PRI_IPO_BIT  = 7;
  localparam int PRI_XTAL_BIT = 6;
  localparam int PRI_WDT_BIT  = 5;

  // ************************************************************
  // System clock select codes
  // ************************************************************
  localparam logic [2:0] SCK_IPO  = 3'h0;
  localparam logic [2:0] SCK_XTAL = 3'h2;
  localparam logic [2:0] SCK_WDT  = 3'h3;
  localparam logic [2:0] SCK_EXT  = 3'h4;

  // ************************************************************
  // Interrupt events
  // ************************************************************
  localparam int IRQ_W         = 4;
  localparam int EV_RDY_RISE   = 0;
  localparam int EV_RDY_FALL   = 1;
  localparam int EV_LOCKED     = 2;
  localparam int EV_KEY_BROKEN = 3;

  // ************************************************************
  // Precision oscillator frequencies in Hz
  // ************************************************************
  localparam logic [23:0] IPO_BASE_HZ = 24'hA8_C000;
  localparam logic [23:0] IPO_LOW6_HZ = 24'h01_5180;
  localparam logic [23:0] IPO_LOW7_HZ = 24'h00_A8C0;
  localparam logic [2:0]  IPO_CODE6   = 3'h6;
  localparam logic [2:0]  IPO_CODE7   = 3'h7;

  typedef enum logic [1:0] {
    KEY_LOCKED = 2'b00,
    KEY_HALF   = 2'b01,
    KEY_OPEN   = 2'b10
  } oscc_key_state_t;

  typedef enum logic [1:0] {
    MODE_MEDIUM  = 2'b00,
    MODE_MAXIMUM = 2'b01,
    MODE_RC_EXT  = 2'b10
  } oscc_main_mode_t;

  function automatic logic [23:0] oscc_ipo_hz(input logic [2:0] sel);
    logic [23:0] hz;
    hz = IPO_BASE_HZ >> sel;
    if (sel == IPO_CODE6) begin
      hz = IPO_LOW6_HZ;
    end else if (sel == IPO_CODE7) begin
      hz = IPO_LOW7_HZ;
    end
    return hz;
  endfunction

endpackage

// ==== rtl/oscc_sync2.sv ====
// Two-stage level synchroniser with clock enable
`timescale 1ns/1ps
module oscc_sync2 (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } oscc_sync_state_t;

  oscc_sync_state_t state_r;
  oscc_sync_state_t state_nxt;

  // ************************************************************
  // Only the second stage is visible outside
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    if (ce_i) begin
      state_nxt.meta = async_i;
      state_nxt.sync = state_r.meta;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_o = state_r.sync;

endmodule

// ==== verif/test_oscillator_control_one_lock.sv ====
// Self-checking testbench of the oscillator control block
`timescale 1ns/1ps
module test_oscillator_control_one_lock;
  import oscc_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic            clock_i, resetn_i, ce_i, wr_i, rd_i, irq_o;
  logic [11:0]     addr_i;
  logic [7:0]      wr_data_i, rd_data_o;
  logic            crystal_disable_option_i, slow_mode_option_i, slow_osc_stable_i;
  logic [1:0]      main_mode_option_i;
  logic            slow_osc_input_i, ipo_clock_i, crystal_clock_i, wdt_clock_i, ext_clock_i;
  logic            slow_osc_enable_o, slow_osc_ready_o, ipo_enable_o, wdt_osc_enable_o;
  logic            crystal_enable_o, crystal_pins_owned_o, system_clock_o, timer_clock_o;
  logic            slow_osc_ext_clock_o;
  logic [2:0]      rc_frequency_select_o, system_clock_select_o;
  logic [23:0]     rc_frequency_hz_o;
  oscc_main_mode_t main_osc_mode_o;
  int              error_cnt, checked, cycles;

  oscc_control DUT (.clock_i, .resetn_i, .ce_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .irq_o,
    .crystal_disable_option_i, .main_mode_option_i, .slow_mode_option_i, .slow_osc_stable_i,
    .slow_osc_input_i, .ipo_clock_i, .crystal_clock_i, .wdt_clock_i, .ext_clock_i, .slow_osc_enable_o,
    .slow_osc_ready_o, .rc_frequency_select_o, .rc_frequency_hz_o, .ipo_enable_o, .wdt_osc_enable_o,
    .crystal_enable_o, .crystal_pins_owned_o, .system_clock_select_o, .system_clock_o, .timer_clock_o,
    .main_osc_mode_o, .slow_osc_ext_clock_o);

  // ************************************************************
  // Bus and compare helpers
  // ************************************************************
  // Every call owns exactly one edge, so strobes never get two drives in one step
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i      <= w;
    rd_i      <= r;
    addr_i    <= a;
    wr_data_i <= d;
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 12'h000, 8'h00);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    idle(1);
    #1 chk("read data", {16'h0000, e}, {16'h0000, rd_data_o});
  endtask
  task automatic cfg(input logic [11:0] a, input logic [7:0] d);
    wr(a, KEY_FIRST);
    wr(a, KEY_SECOND);
    wr(a, d);
    idle(1);
    #1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot();
    rdc(OFS_SECONDARY, SEC_RESET);
    rdc(OFS_PRIMARY, PRI_RESET);
    rdc(12'h0F00, 8'h00);
    chk("main mode", {22'h0, MODE_MAXIMUM}, {22'h0, main_osc_mode_o});
    chk("slow ext", 24'h00_0001, {23'h0, slow_osc_ext_clock_o});
    chk("hz", IPO_BASE_HZ, rc_frequency_hz_o);
    chk("osc enables", 24'h00_0003, {22'h0, ipo_enable_o, wdt_osc_enable_o});
    ipo_clock_i <= 1'b1;
    idle(1);
    #1 chk("sys clock", 24'h00_0001, {23'h0, system_clock_o});
  endtask
  task automatic t_locked();
    wr(OFS_SECONDARY, 8'h80);
    idle(1);
    rdc(OFS_SECONDARY, SEC_RESET);
    rdc(OFS_IRQ_STATUS, 8'h04);
    wr(OFS_IRQ_ENABLE, 8'h04);
    idle(1);
    #1 chk("irq", 24'h00_0001, {23'h0, irq_o});
    wr(OFS_IRQ_ENABLE, 8'h00);
    idle(1);
    #1 chk("irq masked", 24'h00_0000, {23'h0, irq_o});
    wr(OFS_IRQ_ENABLE, 8'h04);
    wr(OFS_IRQ_CLEAR, 8'h04);
    idle(1);
    #1 chk("irq cleared", 24'h00_0000, {23'h0, irq_o});
  endtask
  task automatic t_unlock();
    cfg(OFS_SECONDARY, 8'h83);
    chk("slow enable", 24'h00_0001, {23'h0, slow_osc_enable_o});
    rdc(OFS_SECONDARY, 8'h83);
    wr(OFS_SECONDARY, 8'h00);
    idle(1);
    rdc(OFS_SECONDARY, 8'h83);
  endtask
  task automatic t_codes();
    logic [23:0] e;
    for (int i = 0; i < 8; i++) begin
      cfg(OFS_SECONDARY, 8'(i));
      e = (i == 6) ? IPO_LOW6_HZ : (i == 7) ? IPO_LOW7_HZ : IPO_BASE_HZ >> i;
      chk("select", 24'(i), {21'h0, rc_frequency_select_o});
      chk("hz", e, rc_frequency_hz_o);
    end
  endtask
  task automatic t_ready();
    cfg(OFS_SECONDARY, 8'h83);
    slow_osc_stable_i <= 1'b1;
    slow_osc_input_i  <= 1'b1;
    idle(3);
    #1 chk("ready", 24'h00_0001, {23'h0, slow_osc_ready_o});
    chk("timer clock", 24'h00_0001, {23'h0, timer_clock_o});
    rdc(OFS_SECONDARY, 8'hC3);
    rdc(OFS_IRQ_STATUS, 8'h05);
    cfg(OFS_SECONDARY, 8'h83);
    rdc(OFS_SECONDARY, 8'hC3);
    cfg(OFS_SECONDARY, 8'h43);
    chk("timer off", 24'h00_0000, {23'h0, timer_clock_o});
    rdc(OFS_SECONDARY, 8'h03);
    rdc(OFS_IRQ_STATUS, 8'h07);
  endtask
  task automatic t_broken();
    wr(OFS_IRQ_CLEAR, 8'h0F);
    wr(OFS_SECONDARY, KEY_FIRST);
    wr(OFS_SECONDARY, 8'h55);
    idle(1);
    rdc(OFS_IRQ_STATUS, 8'h08);
    wr(OFS_SECONDARY, 8'h81);
    idle(1);
    rdc(OFS_SECONDARY, 8'h03);
    // Low enable freezes the key locks as well
    ce_i <= 1'b0;
    cfg(OFS_SECONDARY, 8'h85);
    ce_i <= 1'b1;
    rdc(OFS_SECONDARY, 8'h03);
  endtask
  task automatic t_sysclk();
    cfg(OFS_PRIMARY, 8'hC0);
    chk("crystal en", 24'h00_0001, {23'h0, crystal_enable_o});
    chk("pins owned", 24'h00_0001, {23'h0, crystal_pins_owned_o});
    chk("osc enables", 24'h00_0002, {22'h0, ipo_enable_o, wdt_osc_enable_o});
    // Crystal settles for 1000 of its own cycles before it is selected
    repeat (2000) begin
      crystal_clock_i <= ~crystal_clock_i;
      idle(1);
    end
    cfg(OFS_PRIMARY, 8'hC2);
    chk("clock sel", 24'h00_0002, {21'h0, system_clock_select_o});
    crystal_clock_i <= 1'b1;
    ipo_clock_i     <= 1'b0;
    idle(1);
    #1 chk("sys clock", 24'h00_0001, {23'h0, system_clock_o});
    crystal_clock_i <= 1'b0;
    ipo_clock_i     <= 1'b1;
    idle(1);
    #1 chk("sys clock", 24'h00_0000, {23'h0, system_clock_o});
    cfg(OFS_PRIMARY, 8'hC0);
    cfg(OFS_PRIMARY, 8'h80);
    chk("crystal off", 24'h00_0000, {23'h0, crystal_enable_o});
    chk("sys clock", 24'h00_0001, {23'h0, system_clock_o});
  endtask
  task automatic t_reset();
    crystal_disable_option_i <= 1'b0;
    main_mode_option_i       <= 2'b10;
    slow_mode_option_i       <= 1'b0;
    resetn_i                 <= 1'b0;
    idle(2);
    #1 chk("crystal reset", 24'h00_0001, {23'h0, crystal_enable_o});
    resetn_i <= 1'b1;
    idle(2);
    #1 chk("main mode", {22'h0, MODE_RC_EXT}, {22'h0, main_osc_mode_o});
    chk("slow ext", 24'h00_0000, {23'h0, slow_osc_ext_clock_o});
    rdc(OFS_PRIMARY, 8'hE0);
  endtask

  // ************************************************************
  // Clock, timeout and run
  // ************************************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Whole run needs about 2200 cycles, most of them crystal settling
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {error_cnt, checked, cycles} = '0;
    {resetn_i, wr_i, rd_i, addr_i, wr_data_i, slow_osc_stable_i} = '0;
    {slow_osc_input_i, ipo_clock_i, crystal_clock_i, wdt_clock_i, ext_clock_i} = '0;
    ce_i                     = 1'b1;
    crystal_disable_option_i = 1'b1;
    main_mode_option_i       = 2'b01;
    slow_mode_option_i       = 1'b1;
    repeat (8) @(posedge clock_i);
    chk("crystal reset", 24'h00_0000, {23'h0, crystal_enable_o});
    resetn_i <= 1'b1;
    idle(2);
    t_boot();
    t_locked();
    t_unlock();
    t_codes();
    t_ready();
    t_broken();
    t_sysclk();
    t_reset();
    stop_test();
  end
endmodule
